/* File: src/two_level_interrupt_arbiter.sv */
`timescale 1ns/100ps
module two_level_interrupt_arbiter (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [18:0] src_event,
	input  wire logic        supply_warning_flag,
	input  wire logic        port_match,
	input  wire logic        cpu_instr_done,
	input  wire logic        cpu_return_from_interrupt_done,
	output logic             call_start,
	output logic             call_busy,
	output logic      [15:0] call_vector,
	output logic             level_hi_active,
	output logic             level_lo_active
);
	localparam int N = irq_pkg::NUM_SRC;

	// ---------------- register file ----------------
	logic                     global_irq_enable;
	logic [N-1:0]             en;
	logic [N-1:0]             prio;
	logic [N-1:0]             next_en;
	logic [N-1:0]             next_prio;
	logic                     next_global;
	logic [31:0]              next_prdata;
	logic [31:0]              rd_data;
	logic                     acc;
	logic                     setup_rd;
	logic                     hit;
	logic                     wr;
	logic                     wr_pen;
	logic                     wr_ppr;
	logic                     wr_xea;
	logic                     wr_xpa;
	logic                     wr_xeb;
	logic                     wr_xpb;
	logic                     wr_pset;
	logic                     wr_pclr;
	logic [N-1:0]             pend_vec;
	logic [N-1:0]             req_vec;

	// ---------------- arbitration ----------------
	logic [N-1:0]             hi_req;
	logic [N-1:0]             lo_req;
	logic [irq_pkg::IDX_W-1:0] hi_idx;
	logic [irq_pkg::IDX_W-1:0] lo_idx;
	logic                     hi_any;
	logic                     lo_any;
	logic                     hi_ok;
	logic                     lo_ok;
	logic                     win_valid;
	logic [irq_pkg::IDX_W-1:0] win_idx;
	logic                     win_valid_q;
	logic                     win_hi_q;
	logic [irq_pkg::IDX_W-1:0] win_idx_q;
	logic                     take;
	logic                     return_from_interrupt_seen;
	logic [15:0]              next_vector;

	irq_pkg::call_state_t     state;
	irq_pkg::call_state_t     next_state;
	logic [2:0]               call_cnt;
	logic [2:0]               next_cnt;
	logic                     active_hi;
	logic                     active_lo;
	logic                     next_active_hi;
	logic                     next_active_lo;
	logic [irq_pkg::IDX_W-1:0] last_idx;

	// zero wait states: every access completes in its first access cycle
	assign pready   = 1'b1;
	assign acc      = psel & penable;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign hit      = (paddr == irq_pkg::OFS_PRI_EN)   | (paddr == irq_pkg::OFS_PRI_PRIO) |
		(paddr == irq_pkg::OFS_EXT_EN_A) | (paddr == irq_pkg::OFS_EXT_PR_A) |
		(paddr == irq_pkg::OFS_EXT_EN_B) | (paddr == irq_pkg::OFS_EXT_PR_B) |
		(paddr == irq_pkg::OFS_PEND_SET) | (paddr == irq_pkg::OFS_PEND_CLR) |
		(paddr == irq_pkg::OFS_STATUS);
	assign pslverr  = acc & ~hit;
	assign wr       = acc & pwrite & hit;
	assign wr_pen   = wr & (paddr == irq_pkg::OFS_PRI_EN);
	assign wr_ppr   = wr & (paddr == irq_pkg::OFS_PRI_PRIO);
	assign wr_xea   = wr & (paddr == irq_pkg::OFS_EXT_EN_A);
	assign wr_xpa   = wr & (paddr == irq_pkg::OFS_EXT_PR_A);
	assign wr_xeb   = wr & (paddr == irq_pkg::OFS_EXT_EN_B);
	assign wr_xpb   = wr & (paddr == irq_pkg::OFS_EXT_PR_B);
	assign wr_pset  = wr & (paddr == irq_pkg::OFS_PEND_SET);
	assign wr_pclr  = wr & (paddr == irq_pkg::OFS_PEND_CLR);

	assign next_en = wr_pen ? {en[N-1:irq_pkg::EXT_A_BASE], pwdata[6:0]} :
		wr_xea ? {en[N-1:irq_pkg::EXT_B_BASE], pwdata[7:0], en[irq_pkg::EXT_A_BASE-1:0]} :
		wr_xeb ? {pwdata[3:0], en[irq_pkg::EXT_B_BASE-1:0]} : en;
	assign next_prio = wr_ppr ? {prio[N-1:irq_pkg::EXT_A_BASE], pwdata[6:0]} :
		wr_xpa ? {prio[N-1:irq_pkg::EXT_B_BASE], pwdata[7:0], prio[irq_pkg::EXT_A_BASE-1:0]} :
		wr_xpb ? {pwdata[3:0], prio[irq_pkg::EXT_B_BASE-1:0]} : prio;
	assign next_global = wr_pen ? pwdata[irq_pkg::GLOBAL_EN_BIT] : global_irq_enable;

	// unused top bit of the primary priority register reads as one
	assign rd_data =
		(paddr == irq_pkg::OFS_PRI_EN)   ? {24'h00_0000, global_irq_enable, en[6:0]} :
		(paddr == irq_pkg::OFS_PRI_PRIO) ? {24'h00_0000, 1'b1, prio[6:0]} :
		(paddr == irq_pkg::OFS_EXT_EN_A) ? {24'h00_0000, en[14:7]} :
		(paddr == irq_pkg::OFS_EXT_PR_A) ? {24'h00_0000, prio[14:7]} :
		(paddr == irq_pkg::OFS_EXT_EN_B) ? {28'h000_0000, en[18:15]} :
		(paddr == irq_pkg::OFS_EXT_PR_B) ? {28'h000_0000, prio[18:15]} :
		(paddr == irq_pkg::OFS_PEND_SET) ? {13'h0000, pend_vec} :
		(paddr == irq_pkg::OFS_STATUS)   ? {19'h0_0000, last_idx, 4'h0, call_busy,
			win_valid_q, active_hi, active_lo} :
		32'h0000_0000;
	// read data is captured in the setup phase so it is a flop in the access phase
	assign next_prdata = setup_rd ? rd_data : prdata;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			global_irq_enable <= 1'b0;
			en                <= irq_pkg::EN_RESET;
			prio              <= irq_pkg::PRIO_RESET;
			prdata            <= 32'h0000_0000;
		end else begin
			global_irq_enable <= next_global;
			en                <= next_en;
			prio              <= next_prio;
			prdata            <= next_prdata;
		end
	end

	// ---------------- source slots ----------------
	for (genvar i = 0; i < N; i++) begin : g_src
		irq_slot_if sif ();
		assign sif.global_en = global_irq_enable;
		assign sif.enable    = en[i];
		assign sif.hw_event  = src_event[i];
		assign sif.level_in  = (i == irq_pkg::IDX_SUPPLY) ? supply_warning_flag : port_match;
		assign sif.sw_set    = wr_pset & pwdata[i];
		assign sif.sw_clr    = wr_pclr & pwdata[i];
		assign sif.vec_clr   = take & (win_idx_q == irq_pkg::IDX_W'(i));
		assign pend_vec[i]   = sif.pending;
		assign req_vec[i]    = sif.req;
		source_slot #(
			.HW_CLEAR  (irq_pkg::HW_CLEAR_MASK[i]),
			.LEVEL_SRC (irq_pkg::LEVEL_MASK[i])
		) u_slot (
			.ref_clk (ref_clk),
			.arst_n  (arst_n),
			.sif     (sif.slot)
		);
	end

	// ---------------- priority decode ----------------
	assign hi_req = req_vec & prio;
	assign lo_req = req_vec & ~prio;

	always_comb begin
		hi_idx = '0;
		hi_any = 1'b0;
		lo_idx = '0;
		lo_any = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hi_req[i]) begin
				hi_idx = irq_pkg::IDX_W'(i);
				hi_any = 1'b1;
			end
			if (lo_req[i]) begin
				lo_idx = irq_pkg::IDX_W'(i);
				lo_any = 1'b1;
			end
		end
	end

	// decode after return
	// levels as they stand after this edge, so only one instruction follows a return
	assign hi_ok = hi_any & ~next_active_hi;
	assign lo_ok = lo_any & ~next_active_hi & ~next_active_lo;
	assign win_valid = hi_ok | lo_ok;
	assign win_idx   = hi_ok ? hi_idx : lo_idx;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			win_valid_q <= 1'b0;
			win_hi_q    <= 1'b0;
			win_idx_q   <= '0;
		end else begin
			win_valid_q <= win_valid;
			win_hi_q    <= hi_ok;
			win_idx_q   <= win_idx;
		end
	end

	// ---------------- call sequencing ----------------
	// return is no boundary
	// the return itself never launches a call; the next instruction must finish first
	assign return_from_interrupt_seen = cpu_return_from_interrupt_done;
	assign take = (state == irq_pkg::ST_IDLE) & win_valid_q & cpu_instr_done & ~return_from_interrupt_seen;
	assign next_vector = irq_pkg::VEC_BASE +
		(16'(win_idx_q) << irq_pkg::VEC_SHIFT);

	always_comb begin
		next_state = state;
		next_cnt   = call_cnt;
		unique case (state)
			irq_pkg::ST_IDLE: begin
				if (take) begin
					next_state = irq_pkg::ST_CALL;
					next_cnt   = 3'(irq_pkg::CALL_CYCLES - 1);
				end
			end
			irq_pkg::ST_CALL: begin
				if (call_cnt == 3'h0) begin
					next_state = irq_pkg::ST_IDLE;
				end else begin
					next_cnt = call_cnt - 3'h1;
				end
			end
		endcase
	end

	// low level kept
	// returns during a call cannot happen on a real core and are ignored
	assign next_active_hi = (take & win_hi_q) ? 1'b1 :
		(return_from_interrupt_seen & (state == irq_pkg::ST_IDLE) & active_hi) ? 1'b0 : active_hi;
	assign next_active_lo = (take & ~win_hi_q) ? 1'b1 :
		(return_from_interrupt_seen & (state == irq_pkg::ST_IDLE) & ~active_hi) ? 1'b0 : active_lo;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= irq_pkg::ST_IDLE;
			call_cnt  <= 3'h0;
			active_hi <= 1'b0;
			active_lo <= 1'b0;
		end else begin
			state     <= next_state;
			call_cnt  <= next_cnt;
			active_hi <= next_active_hi;
			active_lo <= next_active_lo;
		end
	end

	// reset vector
	// reset outranks everything: while held, no call is issued and the vector is zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			call_start  <= 1'b0;
			call_vector <= irq_pkg::RESET_VECTOR;
			last_idx    <= '0;
		end else begin
			call_start  <= take;
			call_vector <= take ? next_vector : call_vector;
			last_idx    <= take ? win_idx_q : last_idx;
		end
	end

	assign call_busy       = (state == irq_pkg::ST_CALL);
	assign level_hi_active = active_hi;
	assign level_lo_active = active_lo;

	// ---------------- assertions ----------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	call_len_a: assert property ($rose(call_busy) |-> call_busy[*5] ##1 !call_busy)
		else $error("call does not last five cycles");

	start_cause_a: assert property (call_start |->
		$past(win_valid_q) && $past(cpu_instr_done) && !$past(cpu_return_from_interrupt_done))
		else $error("call started without a decoded request at a boundary");

	vec_map_a: assert property (call_start |->
		call_vector == irq_pkg::VEC_BASE + (16'($past(win_idx_q)) << 3))
		else $error("vector does not match source index");

	hi_block_a: assert property (active_hi |-> !take)
		else $error("high routine was preempted");

	lo_wait_a: assert property (take && active_lo |-> win_hi_q)
		else $error("equal level request preempted a low routine");

	level_first_a: assert property (win_valid_q && !win_hi_q |->
		$past(!(|(req_vec & prio)) || next_active_hi))
		else $error("low request chosen over an eligible high one");

	return_from_interrupt_pop_a: assert property (cpu_return_from_interrupt_done && !call_busy && active_hi |=>
		!active_hi && active_lo == $past(active_lo))
		else $error("return did not clear only the high level");

	return_from_interrupt_gap_a: assert property (cpu_return_from_interrupt_done |=> !call_start)
		else $error("call issued straight after a return");

	hw_clear_a: assert property (take && win_idx_q == 5'h00
		&& !src_event[0] && !wr_pset |=> !pend_vec[0])
		else $error("pin flag not cleared on vectoring");

	gate_a: assert property (!global_irq_enable |-> req_vec == 19'h0_0000)
		else $error("request raised with global enable clear");

	detect_a: assert property (cpu_return_from_interrupt_done && !call_busy && !active_hi && (|req_vec)
		|=> win_valid_q)
		else $error("pending request not decoded straight after a return");

	return_from_interrupt_next_a: assert property (cpu_return_from_interrupt_done && !call_busy && win_valid
		##1 cpu_instr_done && !cpu_return_from_interrupt_done |=> call_start)
		else $error("call not issued after the instruction following a return");

	take_now_a: assert property (win_valid_q && cpu_instr_done && !call_busy
		&& !cpu_return_from_interrupt_done |=> call_start)
		else $error("decoded request waited past an instruction boundary");

	supply_ro_a: assert property (wr_pclr && supply_warning_flag |=>
		pend_vec[irq_pkg::IDX_SUPPLY])
		else $error("software cleared the supply warning flag");

	sw_set_a: assert property (wr_pset && pwdata[17] |=> pend_vec[17])
		else $error("software set did not raise the pending flag");

	preempt_c: cover property (active_lo && take && win_hi_q);
	resume_c: cover property (active_hi && active_lo ##1 cpu_return_from_interrupt_done ##1 !active_hi);
	sw_call_c: cover property (wr_pset ##[1:20] call_start);
	back_call_c: cover property (cpu_return_from_interrupt_done ##[1:10] call_start);
endmodule : two_level_interrupt_arbiter

/* File: src/irq_pkg.sv */
package irq_pkg;
	localparam int          NUM_SRC       = 19;
	localparam int          IDX_W         = 5;
	localparam int          CALL_CYCLES   = 5;
	localparam int          DETECT_CYCLES = 1;
	localparam int          IDX_SUPPLY    = 15;
	localparam int          IDX_PORT_MAT  = 16;
	localparam logic [15:0] RESET_VECTOR  = 16'h0000;
	localparam logic [15:0] VEC_BASE      = 16'h0003;
	localparam int          VEC_SHIFT     = 3;
	localparam logic [18:0] HW_CLEAR_MASK = 19'h0_000F;
	localparam logic [18:0] LEVEL_MASK    = 19'h1_8000;
	localparam logic [18:0] EN_RESET      = 19'h0_0000;
	localparam logic [18:0] PRIO_RESET    = 19'h0_0000;
	localparam int          GLOBAL_EN_BIT = 7;
	localparam int          EXT_A_BASE    = 7;
	localparam int          EXT_B_BASE    = 15;
	localparam logic [11:0] OFS_PRI_EN    = 12'h000;
	localparam logic [11:0] OFS_PRI_PRIO  = 12'h004;
	localparam logic [11:0] OFS_EXT_EN_A  = 12'h008;
	localparam logic [11:0] OFS_EXT_PR_A  = 12'h00C;
	localparam logic [11:0] OFS_EXT_EN_B  = 12'h010;
	localparam logic [11:0] OFS_EXT_PR_B  = 12'h014;
	localparam logic [11:0] OFS_PEND_SET  = 12'h018;
	localparam logic [11:0] OFS_PEND_CLR  = 12'h01C;
	localparam logic [11:0] OFS_STATUS    = 12'h020;
	typedef enum logic {ST_IDLE, ST_CALL} call_state_t;
endpackage : irq_pkg

/* File: src/irq_slot_if.sv */
`timescale 1ns/100ps
interface irq_slot_if;
	logic global_en;
	logic enable;
	logic hw_event;
	logic level_in;
	logic sw_set;
	logic sw_clr;
	logic vec_clr;
	logic pending;
	logic req;
	modport slot (input global_en, enable, hw_event, level_in, sw_set, sw_clr, vec_clr,
		output pending, req);
	modport ctrl (output global_en, enable, hw_event, level_in, sw_set, sw_clr, vec_clr,
		input pending, req);
endinterface : irq_slot_if

/* File: src/source_slot.sv */
`timescale 1ns/100ps
module source_slot #(
	parameter bit HW_CLEAR  = 1'b0,
	parameter bit LEVEL_SRC = 1'b0
) (
	input  wire logic    ref_clk,
	input  wire logic    arst_n,
	irq_slot_if.slot     sif
);
	logic pending;
	logic next_pending;
	logic clr_any;

	assign clr_any = sif.sw_clr | (HW_CLEAR & sif.vec_clr);
	// read-only follower
	// set beats clear so an event in the clear cycle survives
	assign next_pending = LEVEL_SRC ? sif.level_in :
		(sif.hw_event | sif.sw_set | (pending & ~clr_any));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 1'b0;
		end else begin
			pending <= next_pending;
		end
	end

	assign sif.pending = pending;
	assign sif.req = pending & sif.enable & sif.global_en;
endmodule : source_slot

/* File: testbench/cpu_model.sv */
`timescale 1ns/100ps
module cpu_model (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       call_busy,
	input  wire logic [3:0] instr_len,
	input  wire logic       return_from_interrupt_req,
	output logic            cpu_instr_done,
	output logic            cpu_return_from_interrupt_done
);
	logic [3:0] cnt;
	logic       return_from_interrupt_pend;
	wire        fire;
	// the call sequence owns the core, so no boundaries meanwhile
	assign fire = (cnt == instr_len - 4'h1) && !call_busy;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt            <= 4'h0;
			return_from_interrupt_pend      <= 1'b0;
			cpu_instr_done <= 1'b0;
			cpu_return_from_interrupt_done  <= 1'b0;
		end else begin
			cnt            <= (fire || call_busy) ? 4'h0 : cnt + 4'h1;
			return_from_interrupt_pend      <= return_from_interrupt_req || (return_from_interrupt_pend && !fire);
			cpu_instr_done <= fire && !return_from_interrupt_pend;
			cpu_return_from_interrupt_done  <= fire && return_from_interrupt_pend;
		end
	end
endmodule : cpu_model

/* File: testbench/test_two_level_interrupt_arbiter.sv */
`timescale 1ns/100ps
module test_two_level_interrupt_arbiter;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = ZERO;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [18:0] src_event = 19'h0_0000;
	logic        supply_warning_flag = 1'b0;
	logic        port_match = 1'b0;
	logic        cpu_instr_done;
	logic        cpu_return_from_interrupt_done;
	logic        call_start;
	logic        call_busy;
	logic [15:0] call_vector;
	logic        level_hi_active;
	logic        level_lo_active;
	logic [3:0]  instr_len = 4'h1;
	logic        return_from_interrupt_req = 1'b0;
	int          miscompares = 0;
	int          num_checks = 0;
	int          calls = 0;
	logic [31:0] rdat;
	logic        rerr;
	int          n;
	int          k;

	two_level_interrupt_arbiter dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .src_event, .supply_warning_flag, .port_match,
		.cpu_instr_done, .cpu_return_from_interrupt_done, .call_start, .call_busy, .call_vector,
		.level_hi_active, .level_lo_active);
	cpu_model cpu (.ref_clk, .arst_n, .call_busy, .instr_len, .return_from_interrupt_req, .cpu_instr_done,
		.cpu_return_from_interrupt_done);

	always #5 ref_clk = ~ref_clk;
	// the start pulse lasts one cycle, so count it here rather than poll
	always @(posedge ref_clk) begin
		#1;
		if (call_start === 1'b1) calls++;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge ref_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (pready !== 1'b1) miscompares++;
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse(input logic [18:0] b);
		@(posedge ref_clk);
		src_event <= b;
		@(posedge ref_clk);
		src_event <= 19'h0_0000;
	endtask : pulse

	task automatic wait_call();
		int c0;
		c0 = calls;
		n = 0;
		while (calls == c0 && n < 200) begin
			@(posedge ref_clk);
			#2;
			n++;
		end
		if (calls == c0) miscompares++;
		k = 0;
		while (call_busy === 1'b1 && k < 20) begin
			k++;
			@(posedge ref_clk);
			#2;
		end
		if (call_busy === 1'b1) miscompares++;
	endtask : wait_call

	task automatic expect_call(input logic [15:0] v, input logic [1:0] lv);
		wait_call();
		check("vector", {16'h0, call_vector}, {16'h0, v});
		check("levels", {30'h0, level_hi_active, level_lo_active}, {30'h0, lv});
	endtask : expect_call

	task automatic return_from_interrupt();
		int t;
		t = 0;
		@(posedge ref_clk);
		return_from_interrupt_req <= 1'b1;
		@(posedge ref_clk);
		return_from_interrupt_req <= 1'b0;
		while (cpu_return_from_interrupt_done !== 1'b1 && t < 50) begin
			@(posedge ref_clk);
			#2;
			t++;
		end
		if (cpu_return_from_interrupt_done !== 1'b1) miscompares++;
		@(posedge ref_clk);
		#2;
	endtask : return_from_interrupt

	task automatic s_regs();
		for (int a = 0; a < 6; a++) begin
			apb(1'b0, 12'(a * 4), ZERO);
			check("reg reset", rdat, (a == 1) ? 32'h0000_0080 : ZERO);
		end
		apb(1'b1, irq_pkg::OFS_EXT_EN_A, 32'hFFFF_FFFF);
		apb(1'b0, irq_pkg::OFS_EXT_EN_A, ZERO);
		check("ext a width", rdat, 32'h0000_00FF);
		apb(1'b1, irq_pkg::OFS_EXT_EN_B, 32'hFFFF_FFFF);
		apb(1'b0, irq_pkg::OFS_EXT_EN_B, ZERO);
		check("ext b width", rdat, 32'h0000_000F);
		apb(1'b1, 12'h040, 32'hFFFF_FFFF);
		apb(1'b0, 12'h040, ZERO);
		check("unmapped err", {31'h0, rerr}, 32'h0000_0001);
		check("unmapped data", rdat, ZERO);
		check("reset vector", {16'h0, call_vector}, {16'h0, irq_pkg::RESET_VECTOR});
	endtask : s_regs

	task automatic s_vectors();
		logic [11:0] a;
		logic [31:0] b;
		for (int i = 0; i < irq_pkg::NUM_SRC; i++) begin
			b = 32'h0000_0001 << i;
			a = (i < 7) ? irq_pkg::OFS_PRI_EN : (i < 15) ? irq_pkg::OFS_EXT_EN_A
				: irq_pkg::OFS_EXT_EN_B;
			apb(1'b1, irq_pkg::OFS_PRI_EN, 32'h0000_0080);
			apb(1'b1, irq_pkg::OFS_EXT_EN_A, ZERO);
			apb(1'b1, irq_pkg::OFS_EXT_EN_B, ZERO);
			apb(1'b1, a, (i < 7) ? (b | 32'h0000_0080) : (i < 15) ? (b >> 7) : (b >> 15));
			if (i == 15) supply_warning_flag <= 1'b1;
			else if (i == 16) port_match <= 1'b1;
			else if (i > 16) apb(1'b1, irq_pkg::OFS_PEND_SET, b);
			else pulse(b[18:0]);
			expect_call(16'(3 + 8 * i), 2'b01);
			if (i < 15) check("detect delay", n, 32'h0000_0002);
			check("call length", k, irq_pkg::CALL_CYCLES);
			apb(1'b0, irq_pkg::OFS_PEND_SET, ZERO);
			check("hw clear", rdat & b, (i < 4) ? ZERO : b);
			apb(1'b1, irq_pkg::OFS_PEND_CLR, b);
			apb(1'b0, irq_pkg::OFS_PEND_SET, ZERO);
			check("sw clear", rdat & b, (i == 15 || i == 16) ? b : ZERO);
			supply_warning_flag <= 1'b0;
			port_match <= 1'b0;
			return_from_interrupt();
			check("return", {31'h0, level_lo_active}, ZERO);
		end
	endtask : s_vectors

	task automatic s_prio();
		int c;
		apb(1'b1, irq_pkg::OFS_PRI_PRIO, 32'h0000_0060);
		apb(1'b0, irq_pkg::OFS_PRI_PRIO, ZERO);
		check("prio bits", rdat, 32'h0000_00E0);
		apb(1'b1, irq_pkg::OFS_EXT_EN_B, ZERO);
		apb(1'b1, irq_pkg::OFS_PRI_EN, 32'h0000_0071);
		c = calls;
		pulse(19'h0_0030);
		repeat (10) @(posedge ref_clk);
		check("global off", calls - c, ZERO);
		apb(1'b0, irq_pkg::OFS_PEND_SET, ZERO);
		check("held pending", rdat, 32'h0000_0030);
		apb(1'b1, irq_pkg::OFS_PRI_EN, 32'h0000_00F1);
		expect_call(16'h002B, 2'b10);
		apb(1'b1, irq_pkg::OFS_PEND_CLR, 32'h0000_0020);
		c = calls;
		pulse(19'h0_0041);
		repeat (20) @(posedge ref_clk);
		check("high not preempted", calls - c, ZERO);
		return_from_interrupt();
		expect_call(16'h0033, 2'b10);
		check("one instr after return", n, 32'h0000_0001);
		apb(1'b1, irq_pkg::OFS_PEND_CLR, 32'h0000_0040);
		return_from_interrupt();
		expect_call(16'h0003, 2'b01);
		pulse(19'h0_0040);
		expect_call(16'h0033, 2'b11);
		apb(1'b1, irq_pkg::OFS_PEND_CLR, 32'h0000_0040);
		return_from_interrupt();
		check("resume low", {30'h0, level_hi_active, level_lo_active}, 32'h1);
		c = calls;
		repeat (20) @(posedge ref_clk);
		check("equal waits", calls - c, ZERO);
		return_from_interrupt();
		expect_call(16'h0023, 2'b01);
		check("return latency", n, 32'h0000_0001);
		apb(1'b1, irq_pkg::OFS_PEND_CLR, 32'h0000_0010);
		return_from_interrupt();
		check("all returned", {30'h0, level_hi_active, level_lo_active}, ZERO);
	endtask : s_prio

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		s_regs();
		s_vectors();
		s_prio();
		finish_test();
	end

	// whole run needs roughly 1000 cycles
	initial begin
		#300_000;
		miscompares++;
		finish_test();
	end
endmodule : test_two_level_interrupt_arbiter
